// >>> logic/dur_defines.svh
// register offsets, reset values and field positions for one reset-defaults channel
// assumes inclusion by the channel register bank and its package users
`ifndef DUR_DEFINES_SVH
`define DUR_DEFINES_SVH
`define DUR_OFF_DIV_LOW 8'h00
`define DUR_OFF_DIV_HIGH 8'h04
`define DUR_OFF_DIV_FRAC 8'h08
`define DUR_OFF_HOLDING 8'h0C
`define DUR_OFF_INT_EN 8'h10
`define DUR_OFF_FIFO_CTL 8'h14
`define DUR_OFF_INT_STAT 8'h18
`define DUR_OFF_LINE_CTL 8'h1C
`define DUR_OFF_MODEM_CTL 8'h20
`define DUR_OFF_LINE_STAT 8'h24
`define DUR_OFF_MODEM_STAT 8'h28
`define DUR_OFF_SCRATCH 8'h2C
`define DUR_OFF_ENH_FEAT 8'h30
`define DUR_OFF_RESUME1 8'h34
`define DUR_OFF_RESUME2 8'h38
`define DUR_OFF_PAUSE1 8'h3C
`define DUR_OFF_PAUSE2 8'h40
`define DUR_OFF_EVT_STAT 8'h44
`define DUR_OFF_EVT_MASK 8'h48
`define DUR_OFF_PINS 8'h4C
`define DUR_RST_DIV_LOW 8'h01
`define DUR_RST_DIV_HIGH 8'h00
`define DUR_RST_ZERO 8'h00
`define DUR_RST_INT_STAT 8'h01
`define DUR_RST_LINE_STAT 8'h60
`define DUR_RST_SCRATCH 8'hFF
`define DUR_BIT_ENH_EN 4
`define DUR_MASK_INT_EN 8'hF0
`define DUR_MASK_FIFO_CTL 8'h30
`define DUR_MASK_MODEM_CTL 8'hE0
`define DUR_BIT_RTS 1
`define DUR_BIT_DTR 0
`define DUR_BIT_OP2 3
`define DUR_BIT_INT_OE 3
`define DUR_EVT_MODEM 0
`define DUR_EVT_DIV 1
`endif

// >>> logic/dur_pkg.sv
// types shared by the channel register bank and its bus carrier
// assumes dur_defines.svh for numeric constants
package dur_pkg;
    typedef logic [7:0] dur_byte_t;
    typedef logic [7:0] dur_addr_t;
    typedef enum logic [1:0] {DUR_IDLE, DUR_ANSWER} dur_bus_state_t;
endpackage : dur_pkg

// >>> logic/dur_bus_if.sv
// bus carrier between the slave front end and the register bank
// assumes a single clock domain
`timescale 1ns/1ps
interface dur_bus_if;
    import dur_pkg::*;
    logic wr_stb;
    logic rd_stb;
    dur_addr_t addr;
    dur_byte_t wdata;
    dur_byte_t rdata;
    modport front (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport bank (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : dur_bus_if

// >>> logic/dur_avalon_front.sv
// avalon-mm slave front end: one access answered per two-cycle handshake
// assumes the master holds its request until waitrequest is seen low
`timescale 1ns/1ps
module dur_avalon_front
    import dur_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    dur_bus_if.front bus
);
    dur_bus_state_t state_q;
    dur_bus_state_t state_d;
    logic [31:0] rdata_q;
    logic wait_q;
    wire req = avs_read | avs_write;
    wire fire = req && (state_q == DUR_IDLE);

    // strobes last one cycle, in the cycle the request is first seen
    assign bus.wr_stb = fire & avs_write;
    assign bus.rd_stb = fire & avs_read;
    assign bus.addr = avs_address;
    assign bus.wdata = avs_writedata[7:0];
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q; // registered, low only in the answer cycle

    // answer in the cycle after the strobe
    always_comb begin
        case (state_q)
            DUR_IDLE: state_d = fire ? DUR_ANSWER : DUR_IDLE;
            DUR_ANSWER: state_d = DUR_IDLE;
            default: state_d = DUR_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= DUR_IDLE;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            wait_q <= ~fire;
            if (fire) begin
                rdata_q <= {24'h00_0000, bus.rdata};
            end
        end
    end
endmodule : dur_avalon_front

// >>> logic/dur_channel.sv
// reset-defaults register bank for one uart channel with avalon-mm access
// assumes a power-up detect input synchronous to clk_sys and asynchronous modem pins
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "dur_defines.svh"
module dur_channel
    import dur_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic power_up,
    input wire logic sleep_mode,
    input wire logic [3:0] modem_in_n,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic serial_out,
    output logic general_output_two_n,
    output logic send_request_n,
    output logic terminal_ready_n,
    output logic receive_ready_n,
    output logic transmit_ready_n,
    output logic irq_out,
    output logic irq_oe
);
    import dur_pkg::*;

    dur_bus_if bus ();
    logic [31:0] front_rdata;
    logic front_wait;

    dur_avalon_front u_front (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(front_rdata),
        .avs_waitrequest(front_wait),
        .bus(bus)
    );

    assign avs_readdata = front_rdata;
    assign avs_waitrequest = front_wait;

    // merge new bits only where the write mask allows
    function automatic dur_byte_t merge(input dur_byte_t old_v, input dur_byte_t new_v,
                                        input dur_byte_t keep);
        merge = (old_v & keep) | (new_v & ~keep);
    endfunction : merge

    // host-visible registers
    dur_byte_t div_low_q;
    dur_byte_t div_high_q;
    dur_byte_t div_frac_q;
    dur_byte_t holding_q;
    dur_byte_t int_en_q;
    dur_byte_t fifo_ctl_q;
    dur_byte_t line_ctl_q;
    dur_byte_t modem_ctl_q;
    dur_byte_t scratch_q;
    dur_byte_t enh_feat_q;
    dur_byte_t resume1_q;
    dur_byte_t resume2_q;
    dur_byte_t pause1_q;
    dur_byte_t pause2_q;
    dur_byte_t int_stat_q;
    dur_byte_t line_stat_q;
    // synchroniser, change and event state
    logic [3:0] modem_chg_q;
    logic [3:0] modem_m1_q;
    logic [3:0] modem_m2_q;
    logic [3:0] modem_prev_q;
    logic [1:0] evt_stat_q;
    logic [1:0] evt_mask_q;
    logic irq_q;
    logic pu_done_q;

    // write decode
    wire enh_on = enh_feat_q[`DUR_BIT_ENH_EN];
    wire dur_byte_t wd = bus.wdata;
    wire wr_div_low = bus.wr_stb && bus.addr == `DUR_OFF_DIV_LOW;
    wire wr_div_high = bus.wr_stb && bus.addr == `DUR_OFF_DIV_HIGH;
    wire wr_div_frac = bus.wr_stb && bus.addr == `DUR_OFF_DIV_FRAC && enh_on;
    wire wr_holding = bus.wr_stb && bus.addr == `DUR_OFF_HOLDING;
    wire wr_int_en = bus.wr_stb && bus.addr == `DUR_OFF_INT_EN;
    wire wr_fifo = bus.wr_stb && bus.addr == `DUR_OFF_FIFO_CTL;
    wire wr_line = bus.wr_stb && bus.addr == `DUR_OFF_LINE_CTL;
    wire wr_modem = bus.wr_stb && bus.addr == `DUR_OFF_MODEM_CTL;
    wire wr_scratch = bus.wr_stb && bus.addr == `DUR_OFF_SCRATCH && !sleep_mode;
    wire wr_enh = bus.wr_stb && bus.addr == `DUR_OFF_ENH_FEAT;
    wire wr_res1 = bus.wr_stb && bus.addr == `DUR_OFF_RESUME1;
    wire wr_res2 = bus.wr_stb && bus.addr == `DUR_OFF_RESUME2;
    wire wr_pau1 = bus.wr_stb && bus.addr == `DUR_OFF_PAUSE1;
    wire wr_pau2 = bus.wr_stb && bus.addr == `DUR_OFF_PAUSE2;
    wire wr_evt = bus.wr_stb && bus.addr == `DUR_OFF_EVT_STAT;
    wire wr_mask = bus.wr_stb && bus.addr == `DUR_OFF_EVT_MASK;
    wire rd_modem_stat = bus.rd_stb && bus.addr == `DUR_OFF_MODEM_STAT;

    // enhanced fields are write-locked unless the enable bit is set
    wire dur_byte_t int_en_keep = enh_on ? 8'h00 : `DUR_MASK_INT_EN;
    wire dur_byte_t fifo_keep = enh_on ? 8'h00 : `DUR_MASK_FIFO_CTL;
    wire dur_byte_t modem_keep = enh_on ? 8'h00 : `DUR_MASK_MODEM_CTL;

    // modem input change detection on the second sync stage
    wire [3:0] modem_edge = modem_m2_q ^ modem_prev_q;
    wire dur_byte_t modem_stat = {~modem_m2_q, modem_chg_q};
    wire div_event = wr_div_low | wr_div_high;

    // read mux; one byte register per 32-bit word:
    // 0x00-0x08 divisor low, high and fraction
    // 0x0c holding, 0x10 interrupt enable, 0x14 fifo control
    // 0x18 interrupt status, 0x1c line control, 0x20 modem control
    // 0x24 line status, 0x28 modem status, 0x2c scratch, 0x30 enhanced feature
    // 0x34-0x40 resume and pause characters
    // 0x44 event status, 0x48 event mask, 0x4c modem control pin bits
    // unmapped offsets read as zero and ignore writes
    dur_byte_t rd_mux;
    always_comb begin
        case (bus.addr)
            `DUR_OFF_DIV_LOW: rd_mux = div_low_q;
            `DUR_OFF_DIV_HIGH: rd_mux = div_high_q;
            `DUR_OFF_DIV_FRAC: rd_mux = div_frac_q;
            `DUR_OFF_HOLDING: rd_mux = holding_q;
            `DUR_OFF_INT_EN: rd_mux = int_en_q;
            `DUR_OFF_FIFO_CTL: rd_mux = fifo_ctl_q;
            `DUR_OFF_INT_STAT: rd_mux = int_stat_q;
            `DUR_OFF_LINE_CTL: rd_mux = line_ctl_q;
            `DUR_OFF_MODEM_CTL: rd_mux = modem_ctl_q;
            `DUR_OFF_LINE_STAT: rd_mux = line_stat_q;
            `DUR_OFF_MODEM_STAT: rd_mux = modem_stat;
            `DUR_OFF_SCRATCH: rd_mux = scratch_q;
            `DUR_OFF_ENH_FEAT: rd_mux = enh_feat_q;
            `DUR_OFF_RESUME1: rd_mux = resume1_q;
            `DUR_OFF_RESUME2: rd_mux = resume2_q;
            `DUR_OFF_PAUSE1: rd_mux = pause1_q;
            `DUR_OFF_PAUSE2: rd_mux = pause2_q;
            `DUR_OFF_EVT_STAT: rd_mux = {6'b00_0000, evt_stat_q};
            `DUR_OFF_EVT_MASK: rd_mux = {6'b00_0000, evt_mask_q};
            `DUR_OFF_PINS: rd_mux = {4'h0, modem_ctl_q[3:0]};
            default: rd_mux = 8'h00;
        endcase
    end
    assign bus.rdata = rd_mux;

    // divisor: defaults only at power-up, pin reset does not touch it
    // power-up wins over the pin reset so a cold start always gets a usable divisor
    always_ff @(posedge clk_sys) begin
        if (power_up) begin
            div_low_q <= `DUR_RST_DIV_LOW;
            div_high_q <= `DUR_RST_DIV_HIGH;
        end else if (rst_b) begin
            if (wr_div_low) begin
                div_low_q <= wd;
            end
            if (wr_div_high) begin
                div_high_q <= wd;
            end
        end
    end

    // holding register keeps whatever it had; no reset branch
    // software must write it before trusting what it reads back
    always_ff @(posedge clk_sys) begin
        if (wr_holding) begin
            holding_q <= wd;
        end
    end

    // control and character registers, held at defaults through reset
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_frac_q <= `DUR_RST_ZERO;
            int_en_q <= `DUR_RST_ZERO;
            fifo_ctl_q <= `DUR_RST_ZERO;
            line_ctl_q <= `DUR_RST_ZERO;
            modem_ctl_q <= `DUR_RST_ZERO;
            enh_feat_q <= `DUR_RST_ZERO;
            resume1_q <= `DUR_RST_ZERO;
            resume2_q <= `DUR_RST_ZERO;
            pause1_q <= `DUR_RST_ZERO;
            pause2_q <= `DUR_RST_ZERO;
            scratch_q <= `DUR_RST_SCRATCH;
            int_stat_q <= `DUR_RST_INT_STAT;
            line_stat_q <= `DUR_RST_LINE_STAT;
        end else begin
            if (wr_div_frac) div_frac_q <= wd;
            if (wr_int_en) int_en_q <= merge(int_en_q, wd, int_en_keep);
            if (wr_fifo) fifo_ctl_q <= merge(fifo_ctl_q, wd, fifo_keep);
            if (wr_line) line_ctl_q <= wd;
            if (wr_modem) modem_ctl_q <= merge(modem_ctl_q, wd, modem_keep);
            if (wr_enh) enh_feat_q <= wd;
            if (wr_res1) resume1_q <= wd;
            if (wr_res2) resume2_q <= wd;
            if (wr_pau1) pause1_q <= wd;
            if (wr_pau2) pause2_q <= wd;
            if (wr_scratch) scratch_q <= wd;
        end
    end

    // modem input synchroniser and change bits; a new change wins over the read clear
    // only the second stage reads the first, so a metastable level never fans out
    always_ff @(posedge clk_sys) begin
        modem_m1_q <= modem_in_n;
        modem_m2_q <= modem_m1_q;
        if (!rst_b) begin
            modem_prev_q <= 4'h0;
            modem_chg_q <= 4'h0;
            pu_done_q <= 1'b0;
        end else begin
            modem_prev_q <= modem_m2_q;
            pu_done_q <= 1'b1;
            modem_chg_q <= ((rd_modem_stat ? 4'h0 : modem_chg_q)
                            | (pu_done_q ? modem_edge : 4'h0));
        end
    end

    // sticky event bits, write one to clear, set wins
    // a clear that meets a new event in the same cycle loses, so no event is missed
    wire [1:0] evt_set = {div_event, |modem_edge & pu_done_q};
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            evt_stat_q <= 2'b00;
            evt_mask_q <= 2'b00;
            irq_q <= 1'b0;
        end else begin
            evt_stat_q <= (evt_stat_q & ~(wr_evt ? wd[1:0] : 2'b00)) | evt_set;
            if (wr_mask) evt_mask_q <= wd[1:0];
            irq_q <= |(evt_stat_q & evt_mask_q);
        end
    end

    // pin outputs; modem control bits drive the active-low modem pins
    // ready pins stay at their idle levels since no data path lives here
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            serial_out <= 1'b1;
            general_output_two_n <= 1'b1;
            send_request_n <= 1'b1;
            terminal_ready_n <= 1'b1;
            receive_ready_n <= 1'b1;
            transmit_ready_n <= 1'b0;
            irq_oe <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            serial_out <= ~line_ctl_q[6]; // break level
            general_output_two_n <= ~modem_ctl_q[`DUR_BIT_OP2];
            send_request_n <= ~modem_ctl_q[`DUR_BIT_RTS];
            terminal_ready_n <= ~modem_ctl_q[`DUR_BIT_DTR];
            receive_ready_n <= 1'b1;
            transmit_ready_n <= 1'b0;
            irq_oe <= modem_ctl_q[`DUR_BIT_INT_OE];
            irq_out <= irq_q;
        end
    end

    // assertions on reset values
    a_reset_line_stat: assert property (@(posedge clk_sys)
        !rst_b |=> line_stat_q == 8'h60 && int_stat_q == 8'h01)
        else $error("line or interrupt status wrong after reset");
    a_reset_scratch: assert property (@(posedge clk_sys)
        !rst_b |=> scratch_q == 8'hFF)
        else $error("scratch not all ones after reset");
    a_div_keep_pin: assert property (@(posedge clk_sys)
        !rst_b && !power_up |=> $stable(div_low_q) && $stable(div_high_q))
        else $error("divisor changed by pin reset");
    a_div_powerup: assert property (@(posedge clk_sys)
        power_up |=> div_low_q == 8'h01 && div_high_q == 8'h00)
        else $error("divisor power-up default wrong");
    a_reset_chars: assert property (@(posedge clk_sys)
        !rst_b |=> {resume1_q, resume2_q, pause1_q, pause2_q, enh_feat_q} == 40'h0)
        else $error("characters not cleared by reset");
    a_reset_ctl_zero: assert property (@(posedge clk_sys)
        !rst_b |=> {div_frac_q, int_en_q, fifo_ctl_q, line_ctl_q} == 32'h0000_0000
        && modem_ctl_q == 8'h00)
        else $error("control registers not cleared by reset");
    a_pins_reset: assert property (@(posedge clk_sys)
        !rst_b |=> serial_out && general_output_two_n && send_request_n && terminal_ready_n
        && receive_ready_n && !transmit_ready_n && !irq_oe)
        else $error("pin reset state wrong");
    a_irq_reset: assert property (@(posedge clk_sys)
        !rst_b |=> !irq_out && !irq_q)
        else $error("interrupt not idle after reset");
    a_modem_chg_rst: assert property (@(posedge clk_sys)
        !rst_b |=> modem_chg_q == 4'h0)
        else $error("modem change bits not cleared");

    // writes land where allowed and nowhere else
    a_scratch_sleep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        sleep_mode |=> $stable(scratch_q))
        else $error("scratch changed in sleep");
    a_enh_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !enh_on |=> $stable(div_frac_q) && $stable(int_en_q[7:4]))
        else $error("enhanced bits changed while locked");
    a_enh_lock_ctl: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !enh_on |=> $stable(fifo_ctl_q[5:4]) && $stable(modem_ctl_q[7:5]))
        else $error("enhanced control bits changed while locked");
    a_char_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_pau2 |=> pause2_q == $past(wd))
        else $error("pause character write lost");
    a_res1_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_res1 |=> resume1_q == $past(wd))
        else $error("resume character write lost");
    a_frac_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_div_frac |=> div_frac_q == $past(wd))
        else $error("fraction write lost while unlocked");
    a_div_low_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_div_low && !power_up |=> div_low_q == $past(wd))
        else $error("divisor low write lost");
    a_holding_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
        wr_holding |=> holding_q == $past(wd))
        else $error("holding write lost");

    // registers hold their value between host writes
    a_div_hold: assert property (@(posedge clk_sys)
        !power_up && !wr_div_low && !wr_div_high |=> $stable(div_low_q) && $stable(div_high_q))
        else $error("divisor changed without a write");
    a_scratch_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !wr_scratch |=> $stable(scratch_q))
        else $error("scratch changed without a write");
    a_chars_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !wr_res1 && !wr_pau1 |=> $stable(resume1_q) && $stable(pause1_q))
        else $error("characters changed without a write");
endmodule : dur_channel

// >>> test/dur_host_model.sv
// host processor model: avalon-mm master issuing one access at a time
// assumes the same clock as the register bank; bench watches read data itself
`timescale 1ns/1ps
module dur_host_model (
    input wire logic clk_sys,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic hung
);
    // idle bus and no hang at time zero
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        hung = 1'b0;
    end

    // request held until waitrequest is low at a rising edge, then released
    task automatic access(input logic [7:0] a, input logic wr, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h00_0000, d};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) hung <= 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : access
endmodule : dur_host_model

// >>> test/tb.sv
// self-checking bench for one channel register bank
// assumes the host model as bus master and offsets from the shared defines
`timescale 1ns/1ps
`include "dur_defines.svh"
module tb;
    import dur_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic power_up = 1'b1;
    logic sleep_mode = 1'b0;
    logic [3:0] modem_in_n;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic serial_out, op2_n, rts_n, dtr_n, rx_rdy_n, tx_rdy_n, irq_out, irq_oe, hung;
    int err_total = 0;
    int checks = 0;
    logic [15:0] exp_q[$];
    dur_byte_t rv[8];
    dur_addr_t offs[15] = '{`DUR_OFF_DIV_LOW, `DUR_OFF_DIV_HIGH, `DUR_OFF_DIV_FRAC,
        `DUR_OFF_INT_EN, `DUR_OFF_FIFO_CTL, `DUR_OFF_INT_STAT, `DUR_OFF_LINE_CTL,
        `DUR_OFF_MODEM_CTL, `DUR_OFF_LINE_STAT, `DUR_OFF_SCRATCH, `DUR_OFF_ENH_FEAT,
        `DUR_OFF_RESUME1, `DUR_OFF_RESUME2, `DUR_OFF_PAUSE1, `DUR_OFF_PAUSE2};
    dur_byte_t rst_v[15] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
        8'h60, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    dur_channel DUT (.clk_sys(clk_sys), .rst_b(rst_b), .power_up(power_up),
        .sleep_mode(sleep_mode), .modem_in_n(modem_in_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_out(serial_out), .general_output_two_n(op2_n), .send_request_n(rts_n),
        .terminal_ready_n(dtr_n), .receive_ready_n(rx_rdy_n),
        .transmit_ready_n(tx_rdy_n), .irq_out(irq_out), .irq_oe(irq_oe));
    dur_host_model host (.clk_sys(clk_sys), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .hung(hung));

    // verdict and end of run
    task automatic close_out();
        $display("errors %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input dur_addr_t a, input dur_byte_t d);
        host.access(a, 1'b1, d);
    endtask : wr

    // note the expected byte, then read; the monitor compares
    task automatic rd(input dur_addr_t a, input dur_byte_t e);
        exp_q.push_back({a, e});
        host.access(a, 1'b0, 8'h00);
    endtask : rd

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_out !== lvl && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("irq_out", 32'(lvl), 32'(irq_out));
    endtask : wait_irq

    task automatic check_pins();
        check("reset pins", 32'h0000_007C,
            32'({serial_out, op2_n, rts_n, dtr_n, rx_rdy_n, tx_rdy_n, irq_oe}));
    endtask : check_pins

    task automatic read_table(input int first);
        for (int i = first; i < 15; i++) rd(offs[i], rst_v[i]);
    endtask : read_table

    // read answers are compared against the oldest note
    always @(posedge clk_sys) begin
        logic [15:0] n;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            n = exp_q.pop_front();
            check($sformatf("reg %h", n[15:8]), {24'h00_0000, n[7:0]}, avs_readdata);
        end
    end

    // a hung access ends the run
    always @(posedge hung) begin
        err_total++;
        close_out();
    end

    // main sequence
    initial begin
        void'($urandom(79374));
        modem_in_n = 4'($urandom);
        for (int i = 0; i < 8; i++) rv[i] = 8'($urandom);
        repeat (16) @(posedge clk_sys);
        check_pins();
        rst_b <= 1'b1;
        power_up <= 1'b0;
        read_table(0);
        rd(`DUR_OFF_MODEM_STAT, {~modem_in_n, 4'h0});
        rd(8'hFC, 8'h00);
        for (int i = 0; i < 4; i++) wr(offs[11 + i], rv[i]);
        wr(`DUR_OFF_DIV_LOW, rv[4]);
        wr(`DUR_OFF_DIV_HIGH, rv[5]);
        wr(`DUR_OFF_SCRATCH, rv[6]);
        wr(`DUR_OFF_LINE_CTL, 8'h03);
        for (int i = 0; i < 4; i++) rd(offs[11 + i], rv[i]);
        @(posedge clk_sys);
        sleep_mode <= 1'b1;
        wr(`DUR_OFF_SCRATCH, ~rv[6]);
        rd(`DUR_OFF_SCRATCH, rv[6]);
        sleep_mode <= 1'b0;
        wr(`DUR_OFF_INT_EN, 8'hFF);
        wr(`DUR_OFF_DIV_FRAC, rv[7]);
        rd(`DUR_OFF_INT_EN, 8'h0F);
        rd(`DUR_OFF_DIV_FRAC, 8'h00);
        wr(`DUR_OFF_ENH_FEAT, 8'h10);
        wr(`DUR_OFF_INT_EN, 8'hFF);
        wr(`DUR_OFF_DIV_FRAC, rv[7]);
        rd(`DUR_OFF_INT_EN, 8'hFF);
        rd(`DUR_OFF_DIV_FRAC, rv[7]);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check_pins();
        rst_b <= 1'b1;
        rd(`DUR_OFF_DIV_LOW, rv[4]);
        rd(`DUR_OFF_DIV_HIGH, rv[5]);
        read_table(2);
        wr(`DUR_OFF_EVT_MASK, 8'h01);
        modem_in_n <= ~modem_in_n;
        wait_irq(1'b1);
        rd(`DUR_OFF_EVT_STAT, 8'h01);
        wr(`DUR_OFF_EVT_MASK, 8'h00);
        wait_irq(1'b0);
        wr(`DUR_OFF_EVT_MASK, 8'h01);
        wait_irq(1'b1);
        wr(`DUR_OFF_EVT_STAT, 8'h01);
        wait_irq(1'b0);
        wr(`DUR_OFF_DIV_LOW, rv[0]);
        rd(`DUR_OFF_EVT_STAT, 8'h02);
        wait_irq(1'b0);
        wr(`DUR_OFF_MODEM_CTL, 8'h08);
        @(negedge clk_sys);
        check("irq_oe", 32'h0000_0001, 32'(irq_oe));
        close_out();
    end
endmodule : tb
